// [src/haptic_port_pkg.sv]
// constants for the haptic driver two-wire register port
// assumes: one 8-bit register index space, reached only over the serial link
package haptic_port_pkg;

    // 7-bit slave addresses
    localparam logic [6:0] UNICAST_ADDR = 7'h5A;
    localparam logic [6:0] BCAST_ADDR   = 7'h58;

    // register space
    localparam int         REG_COUNT    = 256;
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] INDEX_RESET  = 8'h00;
    localparam logic [7:0] INDEX_STEP   = 8'h01;

    // process trigger and broadcast enable bit positions
    localparam logic [7:0] GO_INDEX     = 8'h0C;
    localparam int         GO_BIT       = 0;
    localparam logic [7:0] BCAST_INDEX  = 8'h02;
    localparam int         BCAST_BIT    = 0;

    // bit slot counter inside one byte
    localparam logic [3:0] BIT_FIRST    = 4'h0;
    localparam logic [3:0] BIT_LAST     = 4'h7;
    localparam logic [3:0] ACK_SLOT     = 4'h8;
    localparam logic [3:0] BIT_STEP     = 4'h1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_INDEX,
        ST_WDATA,
        ST_RDATA
    } link_state_t;

endpackage

// [src/stop_mark_if.sv]
// carries the stop marker from the data-line watcher to the link engine
// assumes: both ends sit in the same top module
`timescale 1ns/1ps
interface stop_mark_if;
    logic stop_seen;

    modport watcher (output stop_seen);
    modport engine  (input  stop_seen);
endinterface

// [src/stop_watch.sv]
// records whether the last rising data edge came while the clock was high
// assumes: data and clock are the raw bus levels
`timescale 1ns/1ps
module stop_watch (
    input  wire logic    sda_i,
    input  wire logic    scl_i,
    stop_mark_if.watcher mark
);

    // no reset: the first rising data edge fully defines the level
    always_ff @(posedge sda_i) begin
        mark.stop_seen <= scl_i;
    end

endmodule

// [src/haptic_i2c_register_port.sv]
// two-wire slave port giving a host master access to the driver registers
// assumes: scl_i is the master's clock; sda is open drain, pulled up outside;
// rst_n_i is held low while scl_i pulses at least three times with sda high
`timescale 1ns/1ps
module haptic_i2c_register_port (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output wire logic sda_o,
    output wire logic sda_oe_o,
    input  wire logic process_done_i,
    output logic      process_start_o,
    output logic      broadcast_address_enable_o
);

    haptic_port_pkg::link_state_t state;

    logic [7:0] reg_mem [haptic_port_pkg::REG_COUNT];
    logic [1:0] lrst_sync;
    logic       link_rst;
    logic       rise_smp;
    logic [7:0] shift;
    logic       master_nack;
    logic [3:0] bit_idx;
    logic [7:0] index;
    logic [7:0] tx;
    logic [7:0] sent_byte;
    logic       drive_low;
    logic       fresh;
    logic       stop_taken;
    logic       start_det;
    logic       addr_hit;
    logic       bcast_on;
    logic       done_tgl;
    logic [2:0] done_sync;
    logic       done_evt;
    logic [2:0] go_sync;
    logic [1:0] bc_sync;

    stop_mark_if mark ();

    stop_watch i_stop_watch (
        .sda_i (sda_i),
        .scl_i (scl_i),
        .mark  (mark)
    );

    // open drain: only ever pulls low
    assign sda_o    = 1'h0;
    assign sda_oe_o = drive_low;

    // link-side reset, taken from the system reset
    always_ff @(posedge scl_i) begin
        lrst_sync <= {lrst_sync[0], ~rst_n_i};
    end
    assign link_rst = lrst_sync[1];

    // a low data line at a falling clock, after a high one at the rise or a
    // stop in the idle high phase, means a start was seen in between
    // a stop marker opens one start only, so zero bits after it are plain data
    assign start_det = !sda_i && (rise_smp || (mark.stop_seen && !stop_taken) || fresh);

    assign bcast_on = reg_mem[haptic_port_pkg::BCAST_INDEX][haptic_port_pkg::BCAST_BIT];
    assign addr_hit = (shift[7:1] == haptic_port_pkg::UNICAST_ADDR)
                   || (bcast_on && shift[7:1] == haptic_port_pkg::BCAST_ADDR);

    // sampling on the rising clock edge
    always_ff @(posedge scl_i) begin
        if (link_rst) begin
            rise_smp    <= 1'h0;
            shift       <= haptic_port_pkg::REG_RESET;
            master_nack <= 1'h0;
        end else begin
            rise_smp <= sda_i;
            shift    <= {shift[6:0], sda_i};
            // our own address acknowledge also reads as an acknowledge here
            if (state == haptic_port_pkg::ST_RDATA && bit_idx == haptic_port_pkg::ACK_SLOT) begin
                master_nack <= sda_i;
            end
        end
    end

    // completion event from the system side
    always_ff @(posedge scl_i) begin
        if (link_rst) begin
            done_sync <= 3'h0;
        end else begin
            done_sync <= {done_sync[1:0], done_tgl};
        end
    end
    assign done_evt = done_sync[2] ^ done_sync[1];

    // spent by the start it opened; re-armed by a data rise with clock low
    // limitation: a frame with no such rise before its stop keeps it spent
    always_ff @(negedge scl_i) begin
        if (link_rst) begin
            stop_taken <= 1'h0;
        end else if (start_det) begin
            stop_taken <= 1'h1;
        end else if (!mark.stop_seen) begin
            stop_taken <= 1'h0;
        end
    end

    // all driving happens on the falling edge, so data moves with clock low
    always_ff @(negedge scl_i) begin
        if (link_rst) begin
            state     <= haptic_port_pkg::ST_IDLE;
            bit_idx   <= haptic_port_pkg::BIT_FIRST;
            index     <= haptic_port_pkg::INDEX_RESET;
            tx        <= haptic_port_pkg::REG_RESET;
            sent_byte <= haptic_port_pkg::REG_RESET;
            drive_low <= 1'h0;
            fresh     <= 1'h1;
            for (int i = 0; i < haptic_port_pkg::REG_COUNT; i++) begin
                reg_mem[i] <= haptic_port_pkg::REG_RESET;
            end
        end else begin
            // a bus write in the same cycle overrides the clear below
            if (done_evt) begin
                reg_mem[haptic_port_pkg::GO_INDEX][haptic_port_pkg::GO_BIT] <= 1'h0;
            end
            // no gate on power state: the port serves standby and active alike
            if (start_det) begin
                state     <= haptic_port_pkg::ST_ADDR;
                bit_idx   <= haptic_port_pkg::BIT_FIRST;
                drive_low <= 1'h0;
                fresh     <= 1'h0;
            end else if (state != haptic_port_pkg::ST_IDLE) begin
                if (bit_idx == haptic_port_pkg::BIT_LAST) begin
                    bit_idx <= haptic_port_pkg::ACK_SLOT;
                    unique case (state)
                        haptic_port_pkg::ST_ADDR: begin
                            if (addr_hit) begin
                                drive_low <= 1'h1;
                                // 0xB4 / 0xB5 on the wire: direction bit picks the path
                                state <= shift[0] ? haptic_port_pkg::ST_RDATA
                                                  : haptic_port_pkg::ST_INDEX;
                            end else begin
                                state <= haptic_port_pkg::ST_IDLE;
                            end
                        end
                        haptic_port_pkg::ST_INDEX: begin
                            index     <= shift;
                            drive_low <= 1'h1;
                            state     <= haptic_port_pkg::ST_WDATA;
                        end
                        haptic_port_pkg::ST_WDATA: begin
                            reg_mem[index] <= shift;
                            // index wraps, so the byte count is unbounded
                            index     <= 8'(index + haptic_port_pkg::INDEX_STEP);
                            drive_low <= 1'h1;
                        end
                        haptic_port_pkg::ST_RDATA: begin
                            drive_low <= 1'h0; // master answers in this slot
                        end
                        haptic_port_pkg::ST_IDLE: begin
                            drive_low <= 1'h0;
                        end
                    endcase
                end else if (bit_idx == haptic_port_pkg::ACK_SLOT) begin
                    bit_idx <= haptic_port_pkg::BIT_FIRST;
                    if (state == haptic_port_pkg::ST_RDATA && !master_nack) begin
                        tx        <= {reg_mem[index][6:0], 1'h0};
                        sent_byte <= reg_mem[index];
                        drive_low <= ~reg_mem[index][7];
                        index     <= 8'(index + haptic_port_pkg::INDEX_STEP);
                    end else if (state == haptic_port_pkg::ST_RDATA) begin
                        state     <= haptic_port_pkg::ST_IDLE;
                        drive_low <= 1'h0;
                    end else begin
                        drive_low <= 1'h0;
                    end
                end else begin
                    bit_idx <= 4'(bit_idx + haptic_port_pkg::BIT_STEP);
                    if (state == haptic_port_pkg::ST_RDATA) begin
                        drive_low <= ~tx[7];
                        tx        <= {tx[6:0], 1'h0};
                    end
                end
            end
        end
    end

    // system side: completion toggle out, go and broadcast levels in
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            done_tgl <= 1'h0;
        end else if (process_done_i) begin
            done_tgl <= ~done_tgl;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            go_sync <= 3'h0;
            bc_sync <= 2'h0;
        end else begin
            go_sync <= {go_sync[1:0],
                        reg_mem[haptic_port_pkg::GO_INDEX][haptic_port_pkg::GO_BIT]};
            bc_sync <= {bc_sync[0], bcast_on};
        end
    end

    // rising go starts the process; broadcast writes reach all drivers at once
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            process_start_o            <= 1'h0;
            broadcast_address_enable_o <= 1'h0;
        end else begin
            process_start_o            <= go_sync[1] & ~go_sync[2];
            broadcast_address_enable_o <= bc_sync[1];
        end
    end

    sequence addr_done;
        state == haptic_port_pkg::ST_ADDR && bit_idx == haptic_port_pkg::BIT_LAST && !start_det;
    endsequence

    sequence index_done;
        state == haptic_port_pkg::ST_INDEX && bit_idx == haptic_port_pkg::BIT_LAST && !start_det;
    endsequence

    unicast_ack_a: assert property (
        @(negedge scl_i) disable iff (link_rst)
        addr_done ##0 (shift[7:1] == haptic_port_pkg::UNICAST_ADDR) |=> drive_low)
        else $error("own address not acknowledged");

    bcast_gate_a: assert property (
        @(negedge scl_i) disable iff (link_rst)
        addr_done ##0 (shift[7:1] == haptic_port_pkg::BCAST_ADDR && !bcast_on)
        |=> !drive_low && state == haptic_port_pkg::ST_IDLE)
        else $error("broadcast address answered while disabled");

    foreign_addr_a: assert property (
        @(negedge scl_i) disable iff (link_rst)
        addr_done ##0 !addr_hit |=> state == haptic_port_pkg::ST_IDLE && !drive_low)
        else $error("foreign address not ignored");

    index_ack_a: assert property (
        @(negedge scl_i) disable iff (link_rst)
        index_done |=> drive_low ##1 (state == haptic_port_pkg::ST_WDATA && !drive_low))
        else $error("index byte acknowledge wrong");

    ack_hold_a: assert property (
        @(posedge scl_i) disable iff (link_rst)
        bit_idx == haptic_port_pkg::ACK_SLOT
        && (state == haptic_port_pkg::ST_INDEX || state == haptic_port_pkg::ST_WDATA)
        |-> sda_oe_o)
        else $error("acknowledge not held low");

    write_store_a: assert property (
        @(negedge scl_i) disable iff (link_rst)
        state == haptic_port_pkg::ST_WDATA && bit_idx == haptic_port_pkg::BIT_LAST && !start_det
        |=> reg_mem[$past(index)] == $past(shift)
            && index == 8'($past(index) + haptic_port_pkg::INDEX_STEP))
        else $error("write byte not stored or index not advanced");

    read_bit_a: assert property (
        @(posedge scl_i) disable iff (link_rst)
        state == haptic_port_pkg::ST_RDATA && bit_idx <= haptic_port_pkg::BIT_LAST
        |-> sda_oe_o == !sent_byte[3'(haptic_port_pkg::BIT_LAST - bit_idx)])
        else $error("read bit out of order");

    nack_release_a: assert property (
        @(negedge scl_i) disable iff (link_rst)
        state == haptic_port_pkg::ST_RDATA && bit_idx == haptic_port_pkg::ACK_SLOT
        && master_nack && !start_det
        |=> state == haptic_port_pkg::ST_IDLE && !drive_low)
        else $error("line held after not-acknowledge");

    start_restart_a: assert property (
        @(negedge scl_i) disable iff (link_rst)
        start_det |=> state == haptic_port_pkg::ST_ADDR
                      && bit_idx == haptic_port_pkg::BIT_FIRST && !drive_low)
        else $error("start did not restart the frame");

    go_clear_a: assert property (
        @(negedge scl_i) disable iff (link_rst)
        done_evt && !(state == haptic_port_pkg::ST_WDATA
                      && bit_idx == haptic_port_pkg::BIT_LAST
                      && index == haptic_port_pkg::GO_INDEX && !start_det)
        |=> !reg_mem[haptic_port_pkg::GO_INDEX][haptic_port_pkg::GO_BIT])
        else $error("go bit not cleared on completion");

    start_once_a: assert property (
        @(negedge scl_i) disable iff (link_rst)
        start_det |=> !start_det || rise_smp)
        else $error("spent stop marker opened a second start");

    start_pulse_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        process_start_o |=> !process_start_o)
        else $error("process start longer than one cycle");

endmodule

// [test/two_wire_master.sv]
// two-wire bus master standing at the far side of the register port
// assumes: the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
module two_wire_master (
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            sda_low_o,
    output logic [8:0]      rx_data_o,
    output int              rx_count_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        rx_data_o = 9'h000;
        rx_count_o = 0;
    end

    // hands one result to the bench monitor
    task automatic note(input logic [8:0] v);
        rx_data_o = v;
        rx_count_o++;
    endtask

    // one 6 ns clock period; data moves only while the clock is low
    task automatic bit_slot(input logic b, output logic s);
        #1 sda_low_o = !b;
        #2 scl_o = 1'b1;
        #1 s = sda_i;
        #2 scl_o = 1'b0;
    endtask

    // idle pulses with data high, only needed around reset
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #3 scl_o = 1'b0;
            #3 scl_o = 1'b1;
        end
    endtask

    task automatic start_cond();
        if (scl_o === 1'b0) begin
            #1 sda_low_o = 1'b0;
            #2 scl_o = 1'b1;
        end
        #1 sda_low_o = 1'b1;
        #2 scl_o = 1'b0;
    endtask

    task automatic stop_cond();
        #1 sda_low_o = 1'b1;
        #2 scl_o = 1'b1;
        #1 sda_low_o = 1'b0;
        #2;
    endtask

    // msb first, then the slave's acknowledge slot
    task automatic send_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
        bit_slot(1'b1, s);
        note({s, 8'h00});
    endtask

    // acknowledge all but the last byte, which gets a not-acknowledge
    task automatic recv_byte(input logic last);
        logic [7:0] d;
        logic       s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, s);
            d[i] = s;
        end
        bit_slot(last, s);
        note({1'b0, d});
    endtask
endmodule

// [test/test_haptic_i2c_register_port.sv]
// self-checking bench for the two-wire register port
// assumes: two_wire_master drives the bus; results are checked against a queue
`timescale 1ns/1ps
module test_haptic_i2c_register_port;
    logic       clock_i        = 1'b0;
    logic       rst_n_i        = 1'b0;
    logic       process_done_i = 1'b0;
    logic       live           = 1'b0;
    wire logic  scl, sda_low, sda_wire, sda_o, sda_oe_o;
    wire logic  process_start_o, broadcast_address_enable_o;
    logic [8:0] rx_data;
    int         rx_count;
    logic [8:0] expect_q[$];
    logic [8:0] exp;
    logic [7:0] shadow [256];
    logic [7:0] d[$];
    int         fail_count  = 0;
    int         checks_done = 0;
    int         seed        = 64;

    // wired-and with pull-up
    assign sda_wire = !(sda_low || (sda_oe_o && !sda_o));

    haptic_i2c_register_port i_haptic_i2c_register_port (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .process_done_i(process_done_i),
        .process_start_o(process_start_o),
        .broadcast_address_enable_o(broadcast_address_enable_o));

    two_wire_master i_two_wire_master (.sda_i(sda_wire), .scl_o(scl), .sda_low_o(sda_low),
        .rx_data_o(rx_data), .rx_count_o(rx_count));

    always #10 clock_i = !clock_i;

    task automatic fail(input string msg);
        fail_count++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] q[$],
                      input logic ok);
        logic [7:0] p;
        p = idx;
        repeat (2) expect_q.push_back({!ok, 8'h00});
        i_two_wire_master.start_cond();
        i_two_wire_master.send_byte({a, 1'b0});
        i_two_wire_master.send_byte(idx);
        foreach (q[i]) begin
            expect_q.push_back({!ok, 8'h00});
            if (ok) shadow[p] = q[i];
            p = p + 8'h01;
            i_two_wire_master.send_byte(q[i]);
        end
        i_two_wire_master.stop_cond();
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] idx, input int cnt);
        logic [7:0] p;
        p = idx;
        repeat (3) expect_q.push_back(9'h000);
        i_two_wire_master.start_cond();
        i_two_wire_master.send_byte({a, 1'b0});
        i_two_wire_master.send_byte(idx);
        i_two_wire_master.start_cond();
        i_two_wire_master.send_byte({a, 1'b1});
        for (int k = 0; k < cnt; k++) begin
            expect_q.push_back({1'b0, shadow[p]});
            p = p + 8'h01;
            i_two_wire_master.recv_byte(k == cnt - 1);
        end
        i_two_wire_master.stop_cond();
    endtask

    // takes the oldest note whenever the master reports a result
    initial begin
        forever begin
            @(rx_count);
            if (rx_count != 0) begin
                checks_done++;
                if (expect_q.size() == 0) fail("result with nothing expected");
                else begin
                    exp = expect_q.pop_front();
                    if (rx_data !== exp) fail("bus result differs");
                end
            end
        end
    end

    // device data drive must only move while the clock is low
    always @(sda_oe_o) if (live && scl === 1'b1) fail("data moved with clock high");

    initial begin
        foreach (shadow[i]) shadow[i] = haptic_port_pkg::REG_RESET;
        // link clock pulses through reset so the link side takes it as well
        fork
            i_two_wire_master.idle_clocks(12);
            begin
                repeat (2) @(posedge clock_i);
                rst_n_i <= 1'b1;
            end
        join
        i_two_wire_master.idle_clocks(4);
        live = 1'b1;

        // multi-byte write across the index wrap, read back
        d = {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
        wr(haptic_port_pkg::UNICAST_ADDR, 8'hFE, d, 1'b1);
        rd(haptic_port_pkg::UNICAST_ADDR, 8'hFE, 3);
        rd(haptic_port_pkg::UNICAST_ADDR, 8'hFF, 1);
        $display("test write and read done");

        // foreign and disabled broadcast addresses are ignored
        d = {8'($random(seed))};
        wr(7'h33, 8'hFE, d, 1'b0);
        wr(haptic_port_pkg::BCAST_ADDR, 8'hFE, d, 1'b0);
        rd(haptic_port_pkg::UNICAST_ADDR, 8'hFE, 1);
        $display("test ignored addresses done");

        // enable broadcast, trigger through it, finish the process
        wr(haptic_port_pkg::UNICAST_ADDR, haptic_port_pkg::BCAST_INDEX, {8'h01}, 1'b1);
        // outputs are looked at mid-cycle, where they have settled
        repeat (4) @(negedge clock_i);
        if (broadcast_address_enable_o !== 1'b1) fail("broadcast not enabled");
        wr(haptic_port_pkg::BCAST_ADDR, haptic_port_pkg::GO_INDEX, {8'h01}, 1'b1);
        for (int k = 0; k < 100 && process_start_o !== 1'b1; k++) @(negedge clock_i);
        if (process_start_o !== 1'b1) fail("no process start");
        @(negedge clock_i);
        if (process_start_o !== 1'b0) fail("start not a single pulse");
        @(posedge clock_i);
        process_done_i <= 1'b1;
        @(posedge clock_i);
        process_done_i <= 1'b0;
        shadow[haptic_port_pkg::GO_INDEX] = 8'h00;
        rd(haptic_port_pkg::UNICAST_ADDR, haptic_port_pkg::GO_INDEX, 1);
        $display("test broadcast trigger done");

        if (expect_q.size() != 0) fail("results missing");
        give_verdict();
    end
endmodule
